// file: logic/t16pc_unit.v
// Summary of operation
// R01: both timer channels behave identically, except two-phase
// R02: compare matches invert toggle_ff_a, drive toggle_out_a
// R03: software keeps compare_reg_lo below compare_reg_hi
// R04: buffered low compare loads on high match
// R05: capture, match toggling, output drive separately enabled
// R06: mode 01 captures first on trigger_in_a rise
// R07: separate lo and hi match toggle enables
// R08: software sequences delayed one-shot through interrupts
// R09: capture into first register may invert toggle_ff_a
// R10: frequency mode captures on eight_bit_toggle_ff edges
// R11: mode 10 captures both edges, irq on fall
// R12: trigger_in_b rise loads second capture, raises irq
// R13: two-phase: lo inverts ff a, hi ff b
// R14: two-phase flip-flop b only on first channel
// R15: free-running counter wraps after full 16-bit range
// R16: each compare match raises its own interrupt
// R17: high match clears counter only when enabled
// R18: double buffer bit steers low compare writes
// R19: external edges synchronised, one capture per edge
`timescale 1ns/1ps
`include "t16pc_regs.vh"
module t16pc_unit #(
  parameter HAS_TWO_PHASE = 1,
  parameter TAP1_CYC = `T16PC_TAP1_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  // external trigger and toggle sources
  input wire trigger_in_a,
  input wire trigger_in_b,
  input wire eight_bit_toggle_ff,
  // outputs
  output wire toggle_out_a,
  output wire toggle_out_b,
  output wire irq
);

  localparam CW = 16;

  reg [31:0] rdata_ff;
  reg [7:0] ctrl_ff;
  reg [5:0] tog_ff;
  reg [CW-1:0] cnt_ff;
  reg [CW-1:0] cmp_lo_ff;
  reg [CW-1:0] cmp_lo_buf_ff;
  reg [CW-1:0] cmp_hi_ff;
  reg [CW-1:0] capture_reg_first_ff;
  reg [CW-1:0] capture_reg_second_ff;
  reg [`T16PC_ST_W-1:0] stat_ff;
  reg [`T16PC_ST_W-1:0] mask_ff;
  reg toggle_ff_a;
  reg toggle_ff_b;
  reg out_a_ff;
  reg out_b_ff;
  reg irq_ff;
  reg [10:0] presc_ff;
  reg [3:0] tap_cnt_ff;
  reg sw_cap_ff;

  wire [2:0] pin_in;
  wire [2:0] rise;
  wire [2:0] fall;

  assign pin_in = {eight_bit_toggle_ff, trigger_in_b, trigger_in_a};
  assign reg_rdata = rdata_ff;
  assign toggle_out_a = out_a_ff;
  assign toggle_out_b = out_b_ff;
  assign irq = irq_ff;

  // two stages per pin, third stage only for edge detection
  // pins idle low, so the reset value gives no false edge
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg [2:0] sh_ff;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sh_ff <= 3'h0;
        end else begin
          sh_ff <= {sh_ff[1:0], pin_in[gi]}; // [R19]
        end
      end
      assign rise[gi] = sh_ff[1] & ~sh_ff[2]; // [R19]
      assign fall[gi] = ~sh_ff[1] & sh_ff[2]; // [R19]
    end
  endgenerate

  // control fields
  wire run = ctrl_ff[`T16PC_RUN_BIT];
  wire clear_on_match_en = ctrl_ff[`T16PC_CLR_BIT];
  wire [1:0] clk_sel = ctrl_ff[`T16PC_CLKSEL_LSB +: 2];
  wire [1:0] capture_mode_sel = ctrl_ff[`T16PC_CAPSEL_LSB +: 2];
  wire double_buffer_en = ctrl_ff[`T16PC_DBUF_BIT];
  wire two_phase = ctrl_ff[`T16PC_PHASE_BIT] & (HAS_TWO_PHASE != 0);
  wire toggle_on_lo_match_en = tog_ff[`T16PC_EQLO_BIT];
  wire toggle_on_hi_match_en = tog_ff[`T16PC_EQHI_BIT];

  // register write decode
  wire wr_ctrl = reg_wr & (reg_addr == `T16PC_CTRL_OFS);
  wire wr_tog = reg_wr & (reg_addr == `T16PC_TOG_OFS);
  wire wr_lo = reg_wr & (reg_addr == `T16PC_CMP_LO_OFS);
  wire wr_hi = reg_wr & (reg_addr == `T16PC_CMP_HI_OFS);
  wire wr_stat = reg_wr & (reg_addr == `T16PC_STAT_OFS);
  wire wr_mask = reg_wr & (reg_addr == `T16PC_MASK_OFS);
  wire [1:0] cmd_a = reg_wdata[`T16PC_CMDA_LSB +: 2];
  wire [1:0] cmd_b = reg_wdata[`T16PC_CMDB_LSB +: 2];

  // prescaler: tap_1 base pulse, tap_4 and tap_16 from its count
  // presc_ff is 11 bits, so TAP1_CYC above 2048 never fires
  wire tap1 = (presc_ff == TAP1_CYC - 1);
  wire tap4 = tap1 & (tap_cnt_ff[1:0] == 2'h3);
  wire tap16 = tap1 & (tap_cnt_ff == 4'hF);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= 11'h000;
      tap_cnt_ff <= 4'h0;
    end else if (tap1) begin
      presc_ff <= 11'h000;
      tap_cnt_ff <= tap_cnt_ff + 4'h1;
    end else begin
      presc_ff <= presc_ff + 11'h001;
    end
  end

  // counter advance enable from the selected source
  reg tick;
  always @* begin
    case (clk_sel)
      `T16PC_CLK_EXT: tick = rise[0];
      `T16PC_CLK_TAP1: tick = tap1;
      `T16PC_CLK_TAP4: tick = tap4;
      default: tick = tap16;
    endcase
  end
  wire adv = run & tick;

  // comparators see the value held before the advance
  // no guard for low at or above high; software keeps the order
  wire lo_match = adv & (cnt_ff == cmp_lo_ff); // [R16]
  wire hi_match = adv & (cnt_ff == cmp_hi_ff); // [R16]
  wire clr_cnt = hi_match & clear_on_match_en; // [R17]
  wire ovf = adv & (cnt_ff == 16'hFFFF) & ~clr_cnt;

  // up-counter, wraps naturally through 16'hFFFF
  // the wrap is silent apart from the overflow status bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
    end else if (clr_cnt) begin
      cnt_ff <= 16'h0000; // [R17]
    end else if (adv) begin
      cnt_ff <= cnt_ff + 16'h0001; // [R15]
    end
  end

  // capture events per mode; off mode ignores the pins
  wire m_tdiff = (capture_mode_sel == `T16PC_CAP_TDIFF);
  wire m_pw = (capture_mode_sel == `T16PC_CAP_PWIDTH);
  wire m_freq = (capture_mode_sel == `T16PC_CAP_FREQ);
  wire capture_reg_first_ev = ((m_tdiff | m_pw) & rise[0]) // [R06] [R11]
               | (m_freq & rise[2]) | sw_cap_ff; // [R10]
  wire capture_reg_second_ev = (m_tdiff & rise[1]) // [R12]
               | (m_pw & fall[0]) // [R11]
               | (m_freq & fall[2]); // [R10]
  // pulse-width mode moves the trigger interrupt to the fall
  wire capa_irq_ev = m_pw ? fall[0] : rise[0]; // [R11]

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_reg_first_ff <= 16'h0000;
      capture_reg_second_ff <= 16'h0000;
    end else begin
      if (capture_reg_first_ev) begin
        capture_reg_first_ff <= cnt_ff; // [R05] [R06]
      end
      if (capture_reg_second_ev) begin
        capture_reg_second_ff <= cnt_ff; // [R05] [R12]
      end
    end
  end

  // compare registers and low buffer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_lo_ff <= 16'h0000;
      cmp_lo_buf_ff <= 16'h0000;
      cmp_hi_ff <= 16'h0000;
    end else begin
      if (wr_lo) begin
        cmp_lo_buf_ff <= reg_wdata[CW-1:0]; // [R18]
      end
      // buffered copy uses the old buffer if a write coincides
      if (wr_lo & ~double_buffer_en) begin
        cmp_lo_ff <= reg_wdata[CW-1:0]; // [R18]
      end else if (hi_match & double_buffer_en) begin
        cmp_lo_ff <= cmp_lo_buf_ff; // [R04]
      end
      if (wr_hi) begin
        cmp_hi_ff <= reg_wdata[CW-1:0];
      end
    end
  end

  // control registers; software capture is a one-cycle pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `T16PC_CTRL_RST; // [R18]
      tog_ff <= `T16PC_TOG_RST;
      mask_ff <= `T16PC_ST_RST;
      sw_cap_ff <= 1'b0;
    end else begin
      // capture bit is a strobe only, so it is not stored or read back
      sw_cap_ff <= wr_ctrl & reg_wdata[`T16PC_SWCAP_BIT];
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[7:0];
      end
      if (wr_tog) begin
        tog_ff <= reg_wdata[5:0]; // [R05] [R07]
      end
      if (wr_mask) begin
        mask_ff <= reg_wdata[`T16PC_ST_W-1:0];
      end
    end
  end

  // toggle_ff_a: simultaneous events each invert, so xor them
  wire inv_a = (lo_match & toggle_on_lo_match_en) // [R02] [R07] [R13]
             ^ (hi_match & toggle_on_hi_match_en & ~two_phase) // [R02]
             ^ (capture_reg_first_ev & tog_ff[`T16PC_CAP1T_BIT]) // [R09]
             ^ (capture_reg_second_ev & tog_ff[`T16PC_CAP2T_BIT]);

  // a software command in the same cycle overrides hardware
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_ff_a <= 1'b0;
    end else if (wr_tog & (cmd_a == `T16PC_CMD_INV)) begin
      toggle_ff_a <= ~toggle_ff_a;
    end else if (wr_tog & (cmd_a == `T16PC_CMD_SET)) begin
      toggle_ff_a <= 1'b1;
    end else if (wr_tog & (cmd_a == `T16PC_CMD_CLR)) begin
      toggle_ff_a <= 1'b0;
    end else if (inv_a) begin
      toggle_ff_a <= ~toggle_ff_a; // [R02]
    end
  end

  // second flip-flop exists only on the first channel
  generate
    if (HAS_TWO_PHASE != 0) begin : g_ffb
      wire inv_b = hi_match & toggle_on_hi_match_en & two_phase;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          toggle_ff_b <= 1'b0;
        end else if (wr_tog & (cmd_b == `T16PC_CMD_INV)) begin
          toggle_ff_b <= ~toggle_ff_b;
        end else if (wr_tog & (cmd_b == `T16PC_CMD_SET)) begin
          toggle_ff_b <= 1'b1;
        end else if (wr_tog & (cmd_b == `T16PC_CMD_CLR)) begin
          toggle_ff_b <= 1'b0;
        end else if (inv_b) begin
          toggle_ff_b <= ~toggle_ff_b; // [R13] [R14]
        end
      end
    end else begin : g_noffb
      // second channel: no flip-flop b, output held low
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          toggle_ff_b <= 1'b0;
        end else begin
          toggle_ff_b <= 1'b0; // [R14] [R01]
        end
      end
    end
  endgenerate

  // pin drivers; disabled outputs idle low
  // gating is registered, so a pin follows its enable a cycle late
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else begin
      out_a_ff <= toggle_ff_a & tog_ff[`T16PC_OUTA_BIT]; // [R02] [R05]
      out_b_ff <= toggle_ff_b & tog_ff[`T16PC_OUTB_BIT]; // [R13]
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  wire [`T16PC_ST_W-1:0] ev = {ovf, rise[1], capa_irq_ev,
                               hi_match, lo_match}; // [R06] [R12] [R16]
  wire [`T16PC_ST_W-1:0] clr_bits =
    wr_stat ? reg_wdata[`T16PC_ST_W-1:0] : 5'h00;
  wire [`T16PC_ST_W-1:0] nxt_stat = (stat_ff & ~clr_bits) | ev;
  // irq follows a mask write at once rather than a cycle later
  wire [`T16PC_ST_W-1:0] nxt_mask =
    wr_mask ? reg_wdata[`T16PC_ST_W-1:0] : mask_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= `T16PC_ST_RST;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  // read mux, data valid in the cycle after the strobe
  // command fields always read back as 11, the no-op code
  reg [31:0] nxt_rdata;
  always @* begin
    case (reg_addr)
      `T16PC_CTRL_OFS: nxt_rdata = {24'h000000, ctrl_ff[7:0]};
      `T16PC_TOG_OFS: nxt_rdata = {22'h000000, 4'hF, tog_ff};
      `T16PC_CMP_LO_OFS: nxt_rdata = {16'h0000, cmp_lo_ff};
      `T16PC_CMP_HI_OFS: nxt_rdata = {16'h0000, cmp_hi_ff};
      `T16PC_CAPTURE_REG_FIRST_OFS: nxt_rdata = {16'h0000, capture_reg_first_ff};
      `T16PC_CAPTURE_REG_SECOND_OFS: nxt_rdata = {16'h0000, capture_reg_second_ff};
      `T16PC_CNT_OFS: nxt_rdata = {16'h0000, cnt_ff};
      `T16PC_STAT_OFS: nxt_rdata = {27'h0000000, stat_ff};
      `T16PC_MASK_OFS: nxt_rdata = {27'h0000000, mask_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // data held only for one cycle, zero otherwise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
    end
  end

endmodule

// file: logic/t16pc_regs.vh
`ifndef T16PC_REGS_VH
`define T16PC_REGS_VH

// register byte offsets
`define T16PC_CTRL_OFS 8'h00
`define T16PC_TOG_OFS 8'h04
`define T16PC_CMP_LO_OFS 8'h08
`define T16PC_CMP_HI_OFS 8'h0C
`define T16PC_CAPTURE_REG_FIRST_OFS 8'h10
`define T16PC_CAPTURE_REG_SECOND_OFS 8'h14
`define T16PC_CNT_OFS 8'h18
`define T16PC_STAT_OFS 8'h1C
`define T16PC_MASK_OFS 8'h20

// control register fields
`define T16PC_RUN_BIT 0
`define T16PC_CLR_BIT 1
`define T16PC_CLKSEL_LSB 2
`define T16PC_CAPSEL_LSB 4
`define T16PC_DBUF_BIT 6
`define T16PC_PHASE_BIT 7
`define T16PC_SWCAP_BIT 8
`define T16PC_CTRL_RST 8'h00

// toggle control fields
`define T16PC_EQLO_BIT 0
`define T16PC_EQHI_BIT 1
`define T16PC_CAP1T_BIT 2
`define T16PC_CAP2T_BIT 3
`define T16PC_OUTA_BIT 4
`define T16PC_OUTB_BIT 5
`define T16PC_CMDA_LSB 6
`define T16PC_CMDB_LSB 8
`define T16PC_TOG_RST 6'h00

// flip-flop commands written into the toggle control register
`define T16PC_CMD_INV 2'h0
`define T16PC_CMD_SET 2'h1
`define T16PC_CMD_CLR 2'h2
`define T16PC_CMD_NONE 2'h3

// counter clock selections
`define T16PC_CLK_EXT 2'h0
`define T16PC_CLK_TAP1 2'h1
`define T16PC_CLK_TAP4 2'h2
`define T16PC_CLK_TAP16 2'h3

// capture modes
`define T16PC_CAP_OFF 2'h0
`define T16PC_CAP_TDIFF 2'h1
`define T16PC_CAP_PWIDTH 2'h2
`define T16PC_CAP_FREQ 2'h3

// status and mask bits
`define T16PC_ST_LO 0
`define T16PC_ST_HI 1
`define T16PC_ST_CAPA 2
`define T16PC_ST_TRGB 3
`define T16PC_ST_OVF 4
`define T16PC_ST_W 5
`define T16PC_ST_RST 5'h00

// prescaler timing: tap_1 period and derived clock counts
`define T16PC_TAP1_NS 400
`define T16PC_CLK_MHZ 250
`define T16PC_TAP1_CYC (`T16PC_TAP1_NS * `T16PC_CLK_MHZ / 1000)

`endif

// file: sim/t16pc_properties.sv
`timescale 1ns/1ps
`include "t16pc_regs.vh"
module t16pc_properties #(
  parameter HAS_TWO_PHASE = 1,
  parameter TAP1_CYC = `T16PC_TAP1_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // pins
  input wire trigger_in_a,
  input wire trigger_in_b,
  input wire eight_bit_toggle_ff,
  input wire toggle_out_a,
  input wire toggle_out_b,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] wd1_ff;
  logic [31:0] wd2_ff;
  logic [31:0] wd3_ff;

  // write data delayed to line up with a readback slot
  always @(posedge clk) begin
    wd1_ff <= reg_wdata;
    wd2_ff <= wd1_ff;
    wd3_ff <= wd2_ff;
  end

  rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  hole_zero_a: assert property ($past(reg_rd) &&
    $past(reg_addr) > `T16PC_MASK_OFS |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  ctl_back_a: assert property (
    reg_wr && reg_addr == `T16PC_CTRL_OFS ##2
    reg_rd && reg_addr == `T16PC_CTRL_OFS
    |=> reg_rdata[7:0] == wd3_ff[7:0])
    else $error("control readback wrong");
  tog_back_a: assert property (
    reg_wr && reg_addr == `T16PC_TOG_OFS ##2
    reg_rd && reg_addr == `T16PC_TOG_OFS
    |=> reg_rdata[9:0] == {4'hF, wd3_ff[5:0]})
    else $error("toggle control readback wrong");
  mask_quiet_a: assert property (reg_wr &&
    reg_addr == `T16PC_MASK_OFS && reg_wdata[4:0] == 5'h00
    |-> ##2 !irq)
    else $error("irq high with all masked");
  out_gate_a: assert property (reg_wr &&
    reg_addr == `T16PC_TOG_OFS && !reg_wdata[`T16PC_OUTA_BIT]
    |-> ##2 !toggle_out_a)
    else $error("output a not gated off");
  no_phase_b_a: assert property (
    HAS_TWO_PHASE == 0 |-> !toggle_out_b)
    else $error("output b on second channel");
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_n |-> !irq && !toggle_out_a && !toggle_out_b &&
    reg_rdata == 32'h0)
    else $error("outputs active in reset");
endmodule

bind t16pc_unit t16pc_properties #(
  .HAS_TWO_PHASE(HAS_TWO_PHASE),
  .TAP1_CYC(TAP1_CYC)
) i_t16pc_properties (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .trigger_in_a(trigger_in_a),
  .trigger_in_b(trigger_in_b),
  .eight_bit_toggle_ff(eight_bit_toggle_ff),
  .toggle_out_a(toggle_out_a), .toggle_out_b(toggle_out_b),
  .irq(irq));

// file: sim/t16pc_src.sv
`timescale 1ns/1ps
module t16pc_src (
  // clock
  input wire clk,
  // trigger pins
  output logic trigger_in_a = 1'b0,
  output logic trigger_in_b = 1'b0,
  output logic eight_bit_toggle_ff = 1'b0
);
  // one level change, then a quiet span well past the sync delay
  task automatic put(input int w, input logic v);
    @(posedge clk);
    if (w == 0)
      trigger_in_a <= v;
    else if (w == 1)
      trigger_in_b <= v;
    else
      eight_bit_toggle_ff <= v;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
`include "t16pc_regs.vh"
module tb_top;
  localparam A_CTL = `T16PC_CTRL_OFS;
  localparam A_TOG = `T16PC_TOG_OFS;
  localparam A_LO = `T16PC_CMP_LO_OFS;
  localparam A_HI = `T16PC_CMP_HI_OFS;
  localparam A_C1 = `T16PC_CAPTURE_REG_FIRST_OFS;
  localparam A_C2 = `T16PC_CAPTURE_REG_SECOND_OFS;
  localparam A_CNT = `T16PC_CNT_OFS;
  localparam A_ST = `T16PC_STAT_OFS;
  localparam A_MK = `T16PC_MASK_OFS;
  // output a after ppg pulse i sits in bit i
  localparam logic [13:0] PPG_EXP = 14'h3998;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic same_on = 1'b1;
  int failures = 0;
  int checked = 0;
  int n;
  wire [31:0] reg_rdata, rdata_2;
  wire trigger_in_a, trigger_in_b, eight_bit_toggle_ff;
  wire toggle_out_a, toggle_out_b, irq, out_a_2, out_b_2, irq_2;

  // 4 ns clock
  always #2 clk = ~clk;

  // tap_1 every clock keeps the wrap run short
  t16pc_unit #(.TAP1_CYC(1)) i_t16pc_unit (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trigger_in_a(trigger_in_a), .trigger_in_b(trigger_in_b),
    .eight_bit_toggle_ff(eight_bit_toggle_ff),
    .toggle_out_a(toggle_out_a), .toggle_out_b(toggle_out_b),
    .irq(irq));
  t16pc_unit #(.HAS_TWO_PHASE(0), .TAP1_CYC(1)) i_t16pc_unit_2 (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata_2), .trigger_in_a(trigger_in_a),
    .trigger_in_b(trigger_in_b),
    .eight_bit_toggle_ff(eight_bit_toggle_ff),
    .toggle_out_a(out_a_2), .toggle_out_b(out_b_2), .irq(irq_2));
  t16pc_src i_t16pc_src (.clk(clk), .trigger_in_a(trigger_in_a),
    .trigger_in_b(trigger_in_b),
    .eight_bit_toggle_ff(eight_bit_toggle_ff));

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(nm, reg_rdata, e);
  endtask
  task automatic pa;
    i_t16pc_src.put(0, 1'b1);
    i_t16pc_src.put(0, 1'b0);
  endtask
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // second channel tracks the first until two-phase use
  always @(negedge clk) begin
    if (same_on)
      chk("ch2", {rdata_2[29:0], out_a_2, irq_2},
        {reg_rdata[29:0], toggle_out_a, irq});
  end

  // hang guard, the wrap alone needs about 66k clocks
  initial begin
    #350000;
    failures++;
    wrap_up();
  end

  initial begin
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rc("ctl", A_CTL, 32'h0);
    rc("tog", A_TOG, 32'h3C0);
    rc("cnt", A_CNT, 32'h0);
    rc("hole", 8'h40, 32'h0);
    // external count clock
    wr(A_CTL, 32'h01);
    rc("ctl", A_CTL, 32'h01);
    repeat (5) pa();
    rc("cnt", A_CNT, 32'h5);
    // time difference with the counter held at 5
    wr(A_CTL, 32'h10);
    wr(A_ST, 32'h1F);
    wr(A_TOG, 32'h39C);
    pa();
    rc("capture_reg_first", A_C1, 32'h5);
    chk("out a", toggle_out_a, 1'b1);
    i_t16pc_src.put(1, 1'b1);
    i_t16pc_src.put(1, 1'b0);
    rc("capture_reg_second", A_C2, 32'h5);
    chk("out a", toggle_out_a, 1'b0);
    rc("st", A_ST, 32'h0C);
    // pulse width with the counter held at 7
    wr(A_CTL, 32'h01);
    repeat (2) pa();
    wr(A_CTL, 32'h20);
    wr(A_ST, 32'h1F);
    i_t16pc_src.put(0, 1'b1);
    rc("st", A_ST, 32'h0);
    rc("capture_reg_first", A_C1, 32'h7);
    i_t16pc_src.put(0, 1'b0);
    rc("st", A_ST, 32'h04);
    rc("capture_reg_second", A_C2, 32'h7);
    // frequency, captures on the 8-bit toggle flop
    wr(A_CTL, 32'h31);
    repeat (2) pa();
    i_t16pc_src.put(2, 1'b1);
    rc("capture_reg_first", A_C1, 32'h9);
    repeat (2) pa();
    i_t16pc_src.put(2, 1'b0);
    rc("capture_reg_second", A_C2, 32'h0B);
    // ppg, buffered low compare, clear on high match
    wr(A_LO, 32'h0D);
    wr(A_HI, 32'h0F);
    wr(A_CTL, 32'h43);
    wr(A_LO, 32'h01);
    rc("lo", A_LO, 32'h0D);
    wr(A_TOG, 32'h393);
    rc("tog", A_TOG, 32'h3D3);
    wr(A_ST, 32'h1F);
    wr(A_MK, 32'h03);
    for (int i = 1; i <= 13; i++) begin
      pa();
      chk("out a", toggle_out_a, PPG_EXP[i]);
      if (i == 5) begin
        rc("cnt", A_CNT, 32'h0);
        rc("lo", A_LO, 32'h01);
        rc("st", A_ST, 32'h07);
        chk("irq", irq, 1'b1);
        wr(A_ST, 32'h07);
        wr(A_HI, 32'h03);
        rc("st", A_ST, 32'h0);
        chk("irq", irq, 1'b0);
      end
      if (i == 9) begin
        wr(A_MK, 32'h0);
        wr(A_TOG, 32'h3D1);
      end
    end
    wr(A_TOG, 32'h3C1);
    rc("lo", A_LO, 32'h01);
    chk("out a", toggle_out_a, 1'b0);
    // two-phase, first channel only
    same_on <= 1'b0;
    wr(A_CTL, 32'h81);
    wr(A_TOG, 32'h2B3);
    repeat (2) pa();
    chk("out a", toggle_out_a, 1'b1);
    chk("out b", toggle_out_b, 1'b0);
    repeat (2) pa();
    chk("out b", toggle_out_b, 1'b1);
    chk("out b 2", out_b_2, 1'b0);
    // full 16-bit wrap on tap_1 from a count of 4
    wr(A_ST, 32'h1F);
    wr(A_MK, 32'h10);
    wr(A_CTL, 32'h05);
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    chk("wrap", n >= 65530 && n <= 65538, 1'b1);
    // tap_16 then tap_4 over 160 tap_1 periods, software capture first
    wr(A_CTL, 32'h10D);
    repeat (158) @(posedge clk);
    wr(A_CTL, 32'h00);
    rc("tap16", A_CNT, 32'h0C);
    rc("swcap", A_C1, 32'h02);
    wr(A_CTL, 32'h09);
    repeat (158) @(posedge clk);
    wr(A_CTL, 32'h00);
    rc("tap4", A_CNT, 32'h34);
    // delayed one-shot run by software from the capture interrupt
    wr(A_TOG, 32'h390);
    wr(A_CTL, 32'h11);
    wr(A_ST, 32'h1F);
    wr(A_MK, 32'h04);
    pa();
    chk("irq", irq, 1'b1);
    rc("capture_reg_first", A_C1, 32'h34);
    wr(A_LO, 32'h37);
    wr(A_HI, 32'h39);
    wr(A_TOG, 32'h3D3);
    wr(A_ST, 32'h1F);
    wr(A_MK, 32'h02);
    for (int i = 0; i < 5; i++) begin
      pa();
      chk("one shot", toggle_out_a, i == 2 || i == 3);
    end
    chk("irq", irq, 1'b1);
    // toggles off on the high match, then set and invert commands
    wr(A_TOG, 32'h350);
    repeat (2) @(negedge clk);
    chk("out a", toggle_out_a, 1'b1);
    wr(A_TOG, 32'h310);
    repeat (2) @(negedge clk);
    chk("out a", toggle_out_a, 1'b0);
    wrap_up();
  end
endmodule
